// ---- dv/motor_pwm_compare_preload_tb.sv ----
`timescale 1ns/1ps
`include "motor_pwm_cfg.svh"
module motor_pwm_compare_preload_tb;
  import motor_pwm_pkg::*;
  logic             pclk;
  logic             presetn;
  apb_req_type      req;
  apb_rsp_type      rsp;
  logic             period_end;
  logic             comm_event;
  logic [2:0][12:0] duty;
  logic [2:0]       full;
  logic [11:0]      period;
  logic [5:0]       pst;
  logic [7:0]       pol;
  logic [7:0]       dt;
  logic             eight;
  logic             upd;
  int               miscompares;
  int               check_count;
  int               cycles;
  logic [31:0]      rdata;
  logic             err;

  motor_pwm_compare_preload i_dut (
    .pclk               (pclk),
    .presetn            (presetn),
    .apb_req            (req),
    .apb_rsp            (rsp),
    .period_end         (period_end),
    .comm_event         (comm_event),
    .duty_active        (duty),
    .full_duty_active   (full),
    .period_active      (period),
    .phase_state_active (pst),
    .polarity           (pol),
    .deadtime           (dt),
    .eight_bit_mode     (eight),
    .update_event       (upd)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // cut a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer: setup, access, wait for pready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    rdata = rsp.prdata;
    err   = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h000000, d});
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(name, {24'h000000, exp}, rdata);
  endtask

  // period end or commutation pulse, then watch for the update pulse
  task automatic pulse(input bit comm);
    logic seen;
    seen = 1'b0;
    @(posedge pclk);
    if (comm) comm_event <= 1'b1;
    else period_end <= 1'b1;
    @(posedge pclk);
    comm_event <= 1'b0;
    period_end <= 1'b0;
    repeat (3) begin
      @(posedge pclk);
      seen |= (upd === 1'b1);
    end
    if (!comm) chk("update_event", 32'h1, {31'h0, seen});
  endtask

  task automatic t_reset();
    for (int i = 0; i < 6; i++) rd("phase reg", 8'(4 * i), 8'h00);
    rd("period hi", `OFF_PER_HI, 8'h0F);
    rd("period lo", `OFF_PER_LO, 8'hFF);
    rd("polarity", `OFF_POL, 8'h3F);
    rd("deadtime", `OFF_DT, 8'hFF);
  endtask

  task automatic t_duty();
    wr(`OFF_MOTOR_CONTROL_REGISTER_A, 8'h01);
    wr(`OFF_PH_U_HI, 8'hA5);
    wr(`OFF_PH_U_LO, 8'hFF);
    wr(`OFF_PH_U_HI + `OFF_PH_STRIDE, 8'h3C);
    rd("u hi before update", `OFF_PH_U_HI, 8'h00);
    chk("duty u pending", 32'h0, {19'h0, duty[0]});
    pulse(1'b0);
    chk("duty u held", 32'h0, {19'h0, duty[0]});
    chk("duty v half", 32'h0, {19'h0, duty[1]});
    wr(`OFF_PH_U_LO + `OFF_PH_STRIDE, 8'h48);
    pulse(1'b0);
    chk("duty u", {19'h0, 8'hA5, 5'h1F}, {19'h0, duty[0]});
    chk("duty v", {19'h0, 8'h3C, 5'h09}, {19'h0, duty[1]});
    rd("u lo", `OFF_PH_U_LO, 8'hF8);
  endtask

  task automatic t_period();
    wr(`OFF_PER_HI, 8'hA3);
    wr(`OFF_PER_LO, 8'h5C);
    pulse(1'b0);
    chk("period", 32'h35C, {20'h0, period});
    rd("period hi", `OFF_PER_HI, 8'h03);
  endtask

  task automatic t_modes();
    wr(`OFF_PWM_CTL, 8'hC0);
    wr(`OFF_PH_U_HI, 8'hA5);
    wr(`OFF_PH_U_LO, 8'hFF);
    pulse(1'b0);
    chk("full duty", 32'h1, {29'h0, full});
    chk("eight bit", 32'h1, {31'h0, eight});
    chk("duty u 8bit", {19'h0, 8'hA5, 5'h00}, {19'h0, duty[0]});
    rd("pwm ctl", `OFF_PWM_CTL, 8'h80);
    pulse(1'b0);
    chk("full duty off", 32'h0, {29'h0, full});
  endtask

  task automatic t_pst();
    wr(`OFF_PST, 8'h2A);
    repeat (3) @(posedge pclk);
    chk("pst before comm", 32'h0, {26'h0, pst});
    pulse(1'b1);
    chk("pst after comm", 32'h2A, {26'h0, pst});
    wr(`OFF_MOTOR_CONTROL_REGISTER_A, 8'h03);
    wr(`OFF_PST, 8'h15);
    repeat (2) @(posedge pclk);
    chk("pst direct", 32'h15, {26'h0, pst});
    rd("pst read", `OFF_PST, 8'h15);
  endtask

  task automatic t_lock();
    wr(`OFF_POL, 8'h55);
    rd("pol first", `OFF_POL, 8'h55);
    wr(`OFF_POL, 8'h80);
    rd("pol locked", `OFF_POL, 8'h95);
    chk("polarity out", 32'h95, {24'h0, pol});
    wr(`OFF_DT, 8'h00);
    wr(`OFF_DT, 8'hFF);
    rd("dt locked", `OFF_DT, 8'h80);
    chk("deadtime out", 32'h80, {24'h0, dt});
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wr(`OFF_POL, 8'h0A);
    rd("pol after reset", `OFF_POL, 8'h0A);
  endtask

  task automatic t_unmapped();
    xfer(1'b0, 8'h3C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rdata);
  endtask

  initial begin
    miscompares = 0;
    check_count = 0;
    cycles      = 0;
    presetn     = 1'b0;
    req         = '0;
    period_end  = 1'b0;
    comm_event  = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_duty();
    t_period();
    t_modes();
    t_pst();
    t_unmapped();
    t_lock();
    end_of_test();
  end
endmodule // motor_pwm_compare_preload_tb

// ---- verilog/motor_pwm_cfg.svh ----
`ifndef MOTOR_PWM_CFG_SVH
`define MOTOR_PWM_CFG_SVH
// register byte offsets on the apb slave
`define OFF_PH_U_HI   8'h00
`define OFF_PH_U_LO   8'h04
`define OFF_PH_STRIDE 8'h08
`define OFF_PER_HI    8'h18
`define OFF_PER_LO    8'h1C
`define OFF_PWM_CTL   8'h20
`define OFF_REP       8'h24
`define OFF_MOTOR_CONTROL_REGISTER_A      8'h28
`define OFF_PST       8'h2C
`define OFF_POL       8'h30
`define OFF_DT        8'h34
// field positions
`define MOTOR_CONTROL_REGISTER_A_CKE_BIT  0
`define MOTOR_CONTROL_REGISTER_A_DAC_BIT  1
`define CTL_PMS_BIT   7
`define CTL_FULL_U    6
// reset values
`define RST_PH        8'h00
`define RST_PER_HI    4'hF
`define RST_PER_LO    8'hFF
`define RST_REP       8'h00
`define RST_POL_WO    6'h3F
`define RST_DT        8'hFF
`endif

// ---- verilog/motor_pwm_compare_preload.sv ----
// Contract
// R1: each phase duty is 13 bits: full high byte plus low register bits 7:3.
// R2: phase low registers bits 2:0 reserved; all phase registers reset to zero.
// R3: period high keeps bits 3:0 only, bits 7:4 reserved, resets to 0Fh.
// R4: period low holds the low period byte, resets to FFh.
// R5: both halves written first; pair moves to active only at update event.
// R6: writes land in preload; reads at that address return the active value; PWM control reads return the full-duty preload bits.
// R7: non-phase preloaded registers all move to active together.
// R8: normally that transfer happens on every commutation event; only phase state moves on it here, the others on update event.
// R9: with direct access set, a phase-state write transfers at once.
// R10: software sets write-once bits at startup before other accesses.
// R11: any write to polarity or deadtime register locks its write-once bits.
// R12: locked write-once bits ignore writes until hardware reset.
// R13: repetition counter at zero makes update event and reloads.
// R14: in 8-bit mode active compare keeps only the upper byte.
// R15: full-duty flag forces 100% for one update period, then self-clears.
// R16: setting clock enable loads repetition active value and makes update.
// R17: all three phase compares move to active together on update.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "motor_pwm_cfg.svh"
module motor_pwm_compare_preload #(
  parameter int DUTY_W   = 13,
  parameter int PERIOD_W = 12
) (
  // clock and reset
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // apb slave
  input  wire motor_pwm_pkg::apb_req_type        apb_req,
  output      motor_pwm_pkg::apb_rsp_type        apb_rsp,
  // events from counter and commutation logic
  input  wire logic                              period_end,
  input  wire logic                              comm_event,
  // active values
  output      logic [2:0][DUTY_W-1:0]            duty_active,
  output      logic [2:0]                        full_duty_active,
  output      logic [PERIOD_W-1:0]               period_active,
  output      logic [5:0]                        phase_state_active,
  output      logic [7:0]                        polarity,
  output      logic [7:0]                        deadtime,
  output      logic                              eight_bit_mode,
  output      logic                              update_event
);
  import motor_pwm_pkg::*;

  // apb decode
  logic        rdy_q;
  logic [31:0] rdata_q;
  logic        err_q;
  logic [31:0] rdata_d;
  logic        hit_d;
  wire         acc     = apb_req.psel & apb_req.penable;
  wire         done    = acc & rdy_q;
  wire         wr_en   = done & apb_req.pwrite;
  wire  [7:0]  addr    = apb_req.paddr;
  wire  [7:0]  wd      = apb_req.pwdata[7:0];
  wire         wr_per_hi = wr_en && addr == `OFF_PER_HI;
  wire         wr_per_lo = wr_en && addr == `OFF_PER_LO;
  wire         wr_ctl    = wr_en && addr == `OFF_PWM_CTL;
  wire         wr_rep    = wr_en && addr == `OFF_REP;
  wire         wr_motor_control_register_a   = wr_en && addr == `OFF_MOTOR_CONTROL_REGISTER_A;
  wire         wr_pst    = wr_en && addr == `OFF_PST;
  wire         wr_pol    = wr_en && addr == `OFF_POL;
  wire         wr_dt     = wr_en && addr == `OFF_DT;

  // control state
  logic                 cke_q, dac_q, pms_q;
  logic [2:0]           full_pre_q, full_act_q;
  logic [3:0]           ctl_low_q;
  logic [7:0]           rep_pre_q, rep_act_q, rep_cnt_q;
  logic [5:0]           pst_pre_q, pst_act_q;
  logic [1:0]           pol_rw_q;
  logic [5:0]           pol_wo_q;
  logic                 pol_lock_q;
  logic                 dt_rw_q;
  logic [6:0]           dt_wo_q;
  logic                 dt_lock_q;
  logic                 upd_q;
  logic [3:0]           per_hi_q;
  logic [7:0]           per_lo_q;
  logic                 got_per_hi_q, got_per_lo_q;
  logic [PERIOD_W-1:0]  per_act_q;
  logic [7:0]           pre_hi_q [3];
  logic [7:0]           pre_lo_q [3];
  logic [2:0]           got_hi_q, got_lo_q;
  logic [2:0][DUTY_W-1:0] duty_q, ph_next;
  logic [2:0]           wr_hi, wr_lo;

  // update and transfer events
  wire cke_rise = wr_motor_control_register_a & wd[`MOTOR_CONTROL_REGISTER_A_CKE_BIT] & ~cke_q;
  wire rep_zero = period_end & cke_q & (rep_cnt_q == 8'h00);
  wire upd_evt  = rep_zero | cke_rise; // R13 R16
  wire pairs_ok = &(~(got_hi_q ^ got_lo_q));
  wire ph_go    = upd_evt & pairs_ok & |(got_hi_q & got_lo_q); // R5 R17
  wire per_go   = upd_evt & got_per_hi_q & got_per_lo_q; // R5
  wire pst_dac  = wr_pst & dac_q;
  wire pst_go   = comm_event | pst_dac; // R7 R8 R9
  wire [5:0] pst_next = pst_dac ? wd[5:0] : pst_pre_q;

  // phase compare preloads
  for (genvar i = 0; i < 3; i++) begin : g_phase
    assign wr_hi[i] = wr_en && addr == 8'(`OFF_PH_U_HI + `OFF_PH_STRIDE * i);
    assign wr_lo[i] = wr_en && addr == 8'(`OFF_PH_U_LO + `OFF_PH_STRIDE * i);
    assign ph_next[i] = pms_q ? {pre_hi_q[i], 5'h00} : {pre_hi_q[i], pre_lo_q[i][7:3]}; // R1 R14
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pre_hi_q[i] <= `RST_PH; // R2
        pre_lo_q[i] <= `RST_PH; // R2
        got_hi_q[i] <= 1'b0;
        got_lo_q[i] <= 1'b0;
        duty_q[i]   <= '0;
      end else begin
        if (wr_hi[i]) pre_hi_q[i] <= wd;
        if (wr_lo[i]) pre_lo_q[i] <= {wd[7:3], 3'h0}; // R2
        got_hi_q[i] <= wr_hi[i] | (got_hi_q[i] & ~ph_go);
        got_lo_q[i] <= wr_lo[i] | (got_lo_q[i] & ~ph_go);
        if (ph_go) duty_q[i] <= ph_next[i]; // R17
      end
    end
  end

  // period, control and lock registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_hi_q     <= `RST_PER_HI; // R3
      per_lo_q     <= `RST_PER_LO; // R4
      got_per_hi_q <= 1'b0;
      got_per_lo_q <= 1'b0;
      per_act_q    <= {`RST_PER_HI, `RST_PER_LO};
      cke_q        <= 1'b0;
      dac_q        <= 1'b0;
      pms_q        <= 1'b0;
      ctl_low_q    <= 4'h0;
      full_pre_q   <= 3'h0;
      full_act_q   <= 3'h0;
      rep_pre_q    <= `RST_REP;
      rep_act_q    <= `RST_REP;
      rep_cnt_q    <= `RST_REP;
      pst_pre_q    <= 6'h00;
      pst_act_q    <= 6'h00;
      pol_rw_q     <= 2'h0;
      pol_wo_q     <= `RST_POL_WO;
      pol_lock_q   <= 1'b0;
      dt_rw_q      <= 1'(`RST_DT >> 7);
      dt_wo_q      <= 7'(`RST_DT);
      dt_lock_q    <= 1'b0;
      upd_q        <= 1'b0;
    end else begin
      if (wr_per_hi) per_hi_q <= wd[3:0]; // R3
      if (wr_per_lo) per_lo_q <= wd; // R4
      got_per_hi_q <= wr_per_hi | (got_per_hi_q & ~per_go);
      got_per_lo_q <= wr_per_lo | (got_per_lo_q & ~per_go);
      if (per_go) per_act_q <= {per_hi_q, per_lo_q}; // R5
      if (wr_motor_control_register_a) begin
        cke_q <= wd[`MOTOR_CONTROL_REGISTER_A_CKE_BIT];
        dac_q <= wd[`MOTOR_CONTROL_REGISTER_A_DAC_BIT];
      end
      if (wr_ctl) begin
        pms_q      <= wd[`CTL_PMS_BIT]; // R14
        ctl_low_q  <= wd[3:0];
      end
      for (int k = 0; k < 3; k++) begin
        if (wr_ctl) full_pre_q[k] <= wd[`CTL_FULL_U - k];
        else if (upd_evt) full_pre_q[k] <= 1'b0; // R15
      end
      if (upd_evt) full_act_q <= full_pre_q; // R15
      if (wr_rep) rep_pre_q <= wd;
      if (upd_evt) begin
        rep_act_q <= rep_pre_q; // R13 R16
        rep_cnt_q <= rep_pre_q; // R13
      end else if (period_end && cke_q) begin
        rep_cnt_q <= rep_cnt_q - 8'h01;
      end
      if (wr_pst) pst_pre_q <= wd[5:0]; // R6
      if (pst_go) pst_act_q <= pst_next; // R7 R8 R9
      if (wr_pol) begin
        pol_rw_q   <= wd[7:6];
        pol_lock_q <= 1'b1; // R11
        if (!pol_lock_q) pol_wo_q <= wd[5:0]; // R12
      end
      if (wr_dt) begin
        dt_rw_q   <= wd[7];
        dt_lock_q <= 1'b1; // R11
        if (!dt_lock_q) dt_wo_q <= wd[6:0]; // R12
      end
      upd_q <= upd_evt;
    end
  end

  // read mux returns active values, except the full-duty preload bits at PWM control
  always_comb begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b1;
    case (addr)
      `OFF_PH_U_HI:                    rdata_d[7:0] = duty_q[0][12:5]; // R6
      `OFF_PH_U_LO:                    rdata_d[7:0] = {duty_q[0][4:0], 3'h0};
      `OFF_PH_U_HI + `OFF_PH_STRIDE:   rdata_d[7:0] = duty_q[1][12:5];
      `OFF_PH_U_LO + `OFF_PH_STRIDE:   rdata_d[7:0] = {duty_q[1][4:0], 3'h0};
      `OFF_PH_U_HI + 8'h10:            rdata_d[7:0] = duty_q[2][12:5];
      `OFF_PH_U_LO + 8'h10:            rdata_d[7:0] = {duty_q[2][4:0], 3'h0};
      `OFF_PER_HI:                     rdata_d[3:0] = per_act_q[11:8]; // R3
      `OFF_PER_LO:                     rdata_d[7:0] = per_act_q[7:0];
      `OFF_PWM_CTL: rdata_d[7:0] = {pms_q, full_pre_q[0], full_pre_q[1], full_pre_q[2], ctl_low_q};
      `OFF_REP:                        rdata_d[7:0] = rep_act_q;
      `OFF_MOTOR_CONTROL_REGISTER_A:                       rdata_d[1:0] = {dac_q, cke_q};
      `OFF_PST:                        rdata_d[5:0] = pst_act_q; // R6
      `OFF_POL:                        rdata_d[7:0] = {pol_rw_q, pol_wo_q};
      `OFF_DT:                         rdata_d[7:0] = {dt_rw_q, dt_wo_q};
      default:                         hit_d = 1'b0;
    endcase
  end

  // apb response: one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      rdy_q   <= acc & ~rdy_q;
      rdata_q <= (acc & ~rdy_q & ~apb_req.pwrite) ? rdata_d : 32'h0000_0000;
      err_q   <= acc & ~rdy_q & ~hit_d;
    end
  end

  assign apb_rsp.prdata     = rdata_q;
  assign apb_rsp.pready     = rdy_q;
  assign apb_rsp.pslverr    = err_q;
  assign duty_active        = duty_q;
  assign full_duty_active   = full_act_q;
  assign period_active      = per_act_q;
  assign phase_state_active = pst_act_q;
  assign polarity           = {pol_rw_q, pol_wo_q};
  assign deadtime           = {dt_rw_q, dt_wo_q};
  assign eight_bit_mode     = pms_q;
  assign update_event       = upd_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_low_reserved: assert property ( // R2
    pre_lo_q[0][2:0] == 3'h0 && pre_lo_q[1][2:0] == 3'h0 && pre_lo_q[2][2:0] == 3'h0)
    else $error("phase low reserved bits not zero");
  chk_period_hi_read: assert property ( // R3
    acc && !rdy_q && !apb_req.pwrite && addr == `OFF_PER_HI |=> rdata_q[31:4] == 28'h0)
    else $error("period high reserved bits read nonzero");
  chk_read_active: assert property ( // R6
    acc && !rdy_q && !apb_req.pwrite && addr == `OFF_PH_U_HI
    |=> rdata_q[7:0] == $past(duty_q[0][12:5]))
    else $error("read did not return active value");
  chk_half_pair_hold: assert property ( // R5
    upd_evt && (got_hi_q != got_lo_q) |=> duty_q == $past(duty_q))
    else $error("half written pair was transferred");
  chk_phases_together: assert property ( // R17
    ph_go |=> duty_q == $past(ph_next) && (got_hi_q & ~$past(wr_hi)) == 3'h0
      && (got_lo_q & ~$past(wr_lo)) == 3'h0)
    else $error("phase compares not transferred together");
  chk_eight_bit: assert property ( // R14
    ph_go && pms_q |=> duty_q[0][4:0] == 5'h00 && duty_q[1][4:0] == 5'h00
      && duty_q[2][4:0] == 5'h00)
    else $error("low compare bits kept in 8-bit mode");
  chk_comm_xfer: assert property ( // R8
    comm_event && !wr_pst |=> pst_act_q == $past(pst_pre_q))
    else $error("commutation did not load phase state");
  chk_dac_xfer: assert property ( // R9
    wr_pst && dac_q |=> pst_act_q == $past(wd[5:0]) && pst_pre_q == pst_act_q)
    else $error("direct access write not applied at once");
  chk_lock_set: assert property ( // R11
    wr_pol |=> pol_lock_q [*2])
    else $error("polarity write did not lock");
  chk_lock_hold: assert property ( // R12
    pol_lock_q && wr_pol |=> $stable(pol_wo_q))
    else $error("locked write-once bits changed");
  chk_rep_update: assert property ( // R13
    rep_zero |=> upd_q && rep_cnt_q == $past(rep_pre_q))
    else $error("repetition zero gave no update");
  chk_full_duty: assert property ( // R15
    upd_evt && !wr_ctl |=> full_act_q == $past(full_pre_q) && full_pre_q == 3'h0)
    else $error("full duty flag not moved or cleared");
  chk_cke_update: assert property ( // R16
    cke_rise |=> upd_q && rep_act_q == $past(rep_pre_q))
    else $error("clock enable did not force update");

  chk_period_pair: assert property ( // R5
    upd_evt && (got_per_hi_q != got_per_lo_q) |=> per_act_q == $past(per_act_q))
    else $error("half written period pair was transferred");
  chk_pst_hold: assert property ( // R7
    !comm_event && !wr_pst |=> $stable(pst_act_q))
    else $error("phase state changed without an event");
  chk_dt_lock: assert property ( // R12
    dt_lock_q && wr_dt |=> $stable(dt_wo_q))
    else $error("locked deadtime bits changed");
  chk_rep_count: assert property ( // R13
    period_end && cke_q && !upd_evt |=> rep_cnt_q == $past(rep_cnt_q) - 8'h01)
    else $error("repetition counter did not count down");
  chk_lo_read: assert property ( // R2
    acc && !rdy_q && !apb_req.pwrite && addr == `OFF_PH_U_LO |=> rdata_q[2:0] == 3'h0)
    else $error("phase low reserved bits read nonzero");

  cov_phase_xfer: cover property (ph_go ##[1:20] ph_go);
  cov_comm_xfer:  cover property (comm_event && !dac_q);
  cov_dac_write:  cover property (pst_dac);
  cov_lock_retry: cover property (wr_pol ##[1:10] wr_pol);
  cov_full_duty:  cover property (upd_evt && |full_pre_q);
endmodule // motor_pwm_compare_preload

// ---- verilog/motor_pwm_pkg.sv ----
package motor_pwm_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;
endpackage
